/* File: src/cfsp_alu_flags.sv */
// Flag computation for one ALU result.
// Assumes operands and op are stable in the cycle the update is taken.
`timescale 1ns/100ps
`default_nettype none
module cfsp_alu_flags (
    input wire logic [3:0] i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_carry_in,
    input wire logic i_shift_carry,
    input wire logic i_test_bit,
    output logic [7:0] o_result,
    output logic o_half,
    output logic o_neg,
    output logic o_zero,
    output logic o_carry
);
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic cin;
    always_comb begin
        cin = (i_op == cfsp_pkg::CFSP_OP_ADC || i_op == cfsp_pkg::CFSP_OP_SBC)
            ? i_carry_in : 1'b0;
        low_sum = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin};
        sum = 9'h000;
        o_carry = i_carry_in;
        o_result = i_b;
        case (i_op)
            cfsp_pkg::CFSP_OP_ADD, cfsp_pkg::CFSP_OP_ADC: begin
                sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin};
                o_result = sum[7:0];
                o_carry = sum[8]; // RQ4
            end
            cfsp_pkg::CFSP_OP_SUB, cfsp_pkg::CFSP_OP_SBC: begin
                sum = {1'b0, i_a} - {1'b0, i_b} - {8'h00, cin};
                o_result = sum[7:0];
                o_carry = sum[8]; // RQ4
            end
            cfsp_pkg::CFSP_OP_SHIFT: o_carry = i_shift_carry; // RQ4
            cfsp_pkg::CFSP_OP_BTJ: o_carry = i_test_bit; // RQ4
            default: o_result = i_b;
        endcase
        o_half = low_sum[4]; // RQ1
        o_neg = o_result[7]; // RQ2
        o_zero = (o_result == 8'h00); // RQ3
    end
endmodule
`default_nettype wire

/* File: src/cfsp_pkg.sv */
// Shared constants for the core flag and stack pointer register file.
// Assumes one core clock and a synchronous active-low reset.
package cfsp_pkg;
    // Condition flag bit positions
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_ZERO = 1;
    localparam int FLAG_NEG = 2;
    localparam int FLAG_PRIO_LOW = 3;
    localparam int FLAG_HALF = 4;
    localparam int FLAG_PRIO_HIGH = 5;
    // Undefined flag bits reset to a known value, priority level 3
    localparam logic [7:0] FLAGS_RESET = 8'hE8;
    // Stack window
    localparam logic [15:0] SP_RESET = 16'h017F;
    localparam logic [8:0] SP_FIXED_HIGH = 9'h002;
    localparam int SP_VAR_BITS = 7;
    // Priority encodings {high,low}
    localparam logic [1:0] PRIO_LEVEL0 = 2'h2;
    localparam logic [1:0] PRIO_LEVEL1 = 2'h1;
    localparam logic [1:0] PRIO_LEVEL2 = 2'h0;
    localparam logic [1:0] PRIO_LEVEL3 = 2'h3;
    // Context frame lengths
    localparam logic [2:0] CALL_BYTES = 3'h2;
    localparam logic [2:0] IRQ_BYTES = 3'h5;
    // ALU operation codes
    typedef enum logic [3:0] {
        CFSP_OP_NONE = 4'h0,
        CFSP_OP_ADD = 4'h1,
        CFSP_OP_ADC = 4'h2,
        CFSP_OP_SUB = 4'h3,
        CFSP_OP_SBC = 4'h4,
        CFSP_OP_LOGIC = 4'h5,
        CFSP_OP_SHIFT = 4'h6,
        CFSP_OP_BTJ = 4'h7
    } cfsp_alu_op_t;
    // Context sequencer states
    typedef enum logic [2:0] {
        CFSP_IDLE = 3'h0,
        CFSP_SAVE = 3'h1,
        CFSP_RESTORE = 3'h2
    } cfsp_seq_t;
endpackage

/* File: src/cfsp_regs.sv */
// What this block does
// RQ1 - Half-carry bit 4 set on carry from bit 3 during add, cleared by an add without it, held by other ops.
// RQ2 - Negative bit 2 copies result bit 7 after each data operation.
// RQ3 - Zero bit 1 set when latest result is zero, else cleared.
// RQ4 - Carry bit 0 from arithmetic, bit test, shifts, set and clear ops.
// RQ5 - Priority bits 5,3 encode levels 0..3; level 3 disables interrupts.
// RQ6 - Interrupt entry loads priority with the serviced vector's level.
// RQ7 - Mask, unmask, return, halt, wait and flag pop write priority.
// RQ8 - Stack pointer 16 bits, low 7 variable, upper 9 fixed.
// RQ9 - Reset or stack reinit op sets stack pointer to 017Fh.
// RQ10 - Pointer marks next free byte; post-decrement push, pre-increment pop.
// RQ11 - Pointer wraps in its 128-byte window silently both ways.
// RQ12 - Call uses two stack bytes, interrupt entry five.
// RQ13 - Interrupt save writes program counter low first, then descending.
// RQ14 - Automatic save and restore leave the second index register alone.
// RQ15 - Program counter is 16 bits as low and high bytes, next address.
// RQ16 - Stack pointer low byte is readable and writable by load ops.
// RQ17 - Interrupt return restores context, including priority, from stack.
// RQ18 - Save order: pc low, pc high, first index, accumulator, flags.
//
// Architectural flag, program counter and stack pointer register file.
// Assumes the core keeps memory cycles to the one-byte stack port and
// issues at most one op per cycle; the second index register lives
// outside and no stack op ever touches it.
`timescale 1ns/100ps
`default_nettype none
module cfsp_regs #(
    parameter int SP_BITS = 7
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // ALU flag update
    input wire logic i_alu_valid,
    input wire logic [3:0] i_alu_op,
    input wire logic [7:0] i_alu_a,
    input wire logic [7:0] i_alu_b,
    input wire logic i_shift_carry,
    input wire logic i_test_bit,
    input wire logic i_set_overflow_op,
    input wire logic i_clear_overflow_op,
    // Priority controls
    input wire logic i_mask_interrupts_op,
    input wire logic i_unmask_interrupts_op,
    input wire logic i_halt_op,
    input wire logic i_wait_for_irq_op,
    input wire logic [1:0] i_vector_priority,
    input wire logic i_flags_write,
    input wire logic [7:0] i_flags_wdata,
    // Program counter
    input wire logic i_pc_load,
    input wire logic [15:0] i_pc_wdata,
    input wire logic i_pc_low_write,
    input wire logic i_pc_high_write,
    input wire logic [7:0] i_pc_byte,
    // Stack pointer
    input wire logic i_stack_reinit_op,
    input wire logic i_load_op,
    input wire logic [7:0] i_sp_low_wdata,
    input wire logic i_push,
    input wire logic i_pop,
    // Context sequences
    input wire logic i_call,
    input wire logic i_irq_entry,
    input wire logic i_interrupt_return_op,
    input wire logic [7:0] i_index_x,
    input wire logic [7:0] i_accum,
    input wire logic [7:0] i_stack_rdata,
    output logic [7:0] o_condition_flags,
    output logic [15:0] o_stack_pointer,
    output logic [15:0] o_program_counter,
    output logic [7:0] o_alu_result,
    output logic o_irq_disabled,
    output logic o_stack_we,
    output logic [15:0] o_stack_addr,
    output logic [7:0] o_stack_wdata,
    output logic o_stack_re,
    output logic o_busy,
    output logic o_x_load,
    output logic o_a_load,
    output logic [7:0] o_restore_data
);
    // The fixed high part only fills 16 bits with a 7-bit window
    if (SP_BITS != cfsp_pkg::SP_VAR_BITS) begin
        $error("Stack window width must be 7 bits");
    end

    typedef struct packed {
        logic [7:0] flags;
        logic [SP_BITS-1:0] sp;
        logic [15:0] pc;
        logic [7:0] result;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic re;
        logic x_load;
        logic a_load;
        logic [7:0] rdata;
        cfsp_pkg::cfsp_seq_t seq;
        logic [2:0] step;
        logic [39:0] frame;
        logic [7:0] pc_high_hold;
        logic busy;
        logic irq_off;
    } cfsp_state_t;

    cfsp_state_t cur;
    cfsp_state_t next_cur;

    logic [7:0] alu_res;
    logic alu_half;
    logic alu_neg;
    logic alu_zero;
    logic alu_carry;

    cfsp_alu_flags u_alu (
        .i_op(i_alu_op),
        .i_a(i_alu_a),
        .i_b(i_alu_b),
        .i_carry_in(cur.flags[cfsp_pkg::FLAG_CARRY]),
        .i_shift_carry(i_shift_carry),
        .i_test_bit(i_test_bit),
        .o_result(alu_res),
        .o_half(alu_half),
        .o_neg(alu_neg),
        .o_zero(alu_zero),
        .o_carry(alu_carry)
    );

    // Full address of a window offset
    function automatic logic [15:0] sp_addr(input logic [SP_BITS-1:0] s);
        sp_addr = {cfsp_pkg::SP_FIXED_HIGH, s}; // RQ8
    endfunction

    // Writes both priority bits from a {high,low} pair
    function automatic logic [7:0] put_prio(input logic [7:0] f,
                                            input logic [1:0] p);
        put_prio = f;
        put_prio[cfsp_pkg::FLAG_PRIO_HIGH] = p[1];
        put_prio[cfsp_pkg::FLAG_PRIO_LOW] = p[0];
    endfunction

    always_comb begin
        next_cur = cur;
        next_cur.we = 1'b0;
        next_cur.re = 1'b0;
        next_cur.x_load = 1'b0;
        next_cur.a_load = 1'b0;
        case (cur.seq)
            cfsp_pkg::CFSP_IDLE: begin
                if (i_alu_valid) begin
                    next_cur.result = alu_res;
                    next_cur.flags[cfsp_pkg::FLAG_NEG] = alu_neg; // RQ2
                    next_cur.flags[cfsp_pkg::FLAG_ZERO] = alu_zero; // RQ3
                    if (i_alu_op == cfsp_pkg::CFSP_OP_ADD ||
                        i_alu_op == cfsp_pkg::CFSP_OP_ADC) begin
                        next_cur.flags[cfsp_pkg::FLAG_HALF] = alu_half; // RQ1
                    end
                    next_cur.flags[cfsp_pkg::FLAG_CARRY] = alu_carry; // RQ4
                end
                if (i_set_overflow_op) begin
                    next_cur.flags[cfsp_pkg::FLAG_CARRY] = 1'b1; // RQ4
                end else if (i_clear_overflow_op) begin
                    next_cur.flags[cfsp_pkg::FLAG_CARRY] = 1'b0; // RQ4
                end
                // Halt and wait open interrupts like unmask does
                if (i_mask_interrupts_op) begin
                    next_cur.flags = put_prio(next_cur.flags,
                        cfsp_pkg::PRIO_LEVEL3); // RQ7
                end else if (i_unmask_interrupts_op || i_halt_op ||
                             i_wait_for_irq_op) begin
                    next_cur.flags = put_prio(next_cur.flags,
                        cfsp_pkg::PRIO_LEVEL0); // RQ7
                end
                if (i_flags_write) begin
                    next_cur.flags = i_flags_wdata; // RQ7
                end
                if (i_pc_load) begin
                    next_cur.pc = i_pc_wdata; // RQ15
                end
                if (i_pc_low_write) begin
                    next_cur.pc[7:0] = i_pc_byte; // RQ15
                end
                if (i_pc_high_write) begin
                    next_cur.pc[15:8] = i_pc_byte; // RQ15
                end
                if (i_stack_reinit_op) begin
                    next_cur.sp = cfsp_pkg::SP_RESET[SP_BITS-1:0]; // RQ9
                end else if (i_load_op) begin
                    next_cur.sp = i_sp_low_wdata[SP_BITS-1:0]; // RQ16
                end else if (i_push) begin
                    next_cur.sp = cur.sp - 1'b1; // RQ10 RQ11
                end else if (i_pop) begin
                    next_cur.sp = cur.sp + 1'b1; // RQ10 RQ11
                end
                if (i_irq_entry) begin
                    // Frame is shifted out low byte first
                    next_cur.frame = {cur.flags, i_accum, i_index_x,
                                      cur.pc[15:8], cur.pc[7:0]}; // RQ18
                    next_cur.step = cfsp_pkg::IRQ_BYTES; // RQ12
                    next_cur.seq = cfsp_pkg::CFSP_SAVE;
                    next_cur.flags = put_prio(cur.flags,
                        i_vector_priority); // RQ6
                end else if (i_call) begin
                    next_cur.frame = {24'h000000, cur.pc[15:8],
                                      cur.pc[7:0]};
                    next_cur.step = cfsp_pkg::CALL_BYTES; // RQ12
                    next_cur.seq = cfsp_pkg::CFSP_SAVE;
                end else if (i_interrupt_return_op) begin
                    next_cur.step = cfsp_pkg::IRQ_BYTES;
                    next_cur.seq = cfsp_pkg::CFSP_RESTORE;
                    next_cur.sp = cur.sp + 1'b1; // RQ10
                    next_cur.re = 1'b1;
                    next_cur.addr = sp_addr(cur.sp + 1'b1);
                end
            end
            cfsp_pkg::CFSP_SAVE: begin
                // Low byte goes at the free slot, then descending
                next_cur.we = 1'b1; // RQ13
                next_cur.addr = sp_addr(cur.sp);
                next_cur.wdata = cur.frame[7:0];
                next_cur.frame = {8'h00, cur.frame[39:8]};
                next_cur.sp = cur.sp - 1'b1; // RQ10 RQ11
                next_cur.step = cur.step - 1'b1;
                if (cur.step == 3'h1) begin
                    next_cur.seq = cfsp_pkg::CFSP_IDLE;
                end
            end
            cfsp_pkg::CFSP_RESTORE: begin
                // Reverse order: flags, accumulator, index, pc high, pc low
                if (cur.re) begin
                    next_cur.rdata = i_stack_rdata;
                    case (cur.step)
                        3'h5: next_cur.flags = i_stack_rdata; // RQ17
                        3'h4: next_cur.a_load = 1'b1;
                        3'h3: next_cur.x_load = 1'b1; // RQ14
                        3'h2: next_cur.pc_high_hold = i_stack_rdata;
                        default: next_cur.pc = {cur.pc_high_hold,
                                                i_stack_rdata}; // RQ17
                    endcase
                    next_cur.step = cur.step - 1'b1;
                    if (cur.step == 3'h1) begin
                        next_cur.seq = cfsp_pkg::CFSP_IDLE;
                    end else begin
                        next_cur.sp = cur.sp + 1'b1; // RQ10 RQ11
                        next_cur.re = 1'b1;
                        next_cur.addr = sp_addr(cur.sp + 1'b1);
                    end
                end
            end
            default: next_cur.seq = cfsp_pkg::CFSP_IDLE;
        endcase
        if (!i_reset_n) begin
            next_cur = '0;
            next_cur.flags = cfsp_pkg::FLAGS_RESET;
            next_cur.sp = cfsp_pkg::SP_RESET[SP_BITS-1:0]; // RQ9
            next_cur.seq = cfsp_pkg::CFSP_IDLE;
        end
        // Status outputs kept as flops, in step with seq and flags
        next_cur.busy = (next_cur.seq != cfsp_pkg::CFSP_IDLE);
        // Level 3 masks all maskable sources
        next_cur.irq_off = ({next_cur.flags[cfsp_pkg::FLAG_PRIO_HIGH],
                             next_cur.flags[cfsp_pkg::FLAG_PRIO_LOW]}
                            == cfsp_pkg::PRIO_LEVEL3); // RQ5
    end

    always_ff @(posedge i_sys_clk) begin
        cur <= next_cur;
    end

    // Outputs are all register bits or fixed constants beside them
    always_comb begin
        o_condition_flags = cur.flags;
        o_stack_pointer = sp_addr(cur.sp); // RQ8
        o_program_counter = cur.pc;
        o_alu_result = cur.result;
        o_stack_we = cur.we;
        o_stack_addr = cur.addr;
        o_stack_wdata = cur.wdata;
        o_stack_re = cur.re;
        o_busy = cur.busy;
        o_x_load = cur.x_load;
        o_a_load = cur.a_load;
        o_restore_data = cur.rdata;
        o_irq_disabled = cur.irq_off; // RQ5
    end
endmodule
`default_nettype wire

/* File: verif/cfsp_regs_properties.sv */
// Port assertions for the flag and stack pointer register file.
// Assumes binding to cfsp_regs; one clock, sync active-low reset.
`timescale 1ns/100ps
`default_nettype none
module cfsp_regs_properties #(
    parameter int SP_BITS = 7
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_alu_valid,
    input wire logic i_mask_interrupts_op,
    input wire logic i_flags_write,
    input wire logic i_stack_reinit_op,
    input wire logic i_load_op,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic i_call,
    input wire logic i_irq_entry,
    input wire logic i_interrupt_return_op,
    input wire logic [1:0] i_vector_priority,
    input wire logic [7:0] o_condition_flags,
    input wire logic [15:0] o_stack_pointer,
    input wire logic [15:0] o_program_counter,
    input wire logic [7:0] o_alu_result,
    input wire logic o_irq_disabled,
    input wire logic o_stack_we,
    input wire logic [15:0] o_stack_addr,
    input wire logic [7:0] o_stack_wdata,
    input wire logic o_busy
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    logic seq_op;
    logic sp_free;
    assign seq_op = i_call | i_irq_entry | i_interrupt_return_op;
    assign sp_free = !o_busy && !seq_op && !i_stack_reinit_op && !i_load_op;
    sequence s_irq_take;
        i_irq_entry && !o_busy;
    endsequence
    // Busy rises a cycle before the first write and falls with the last
    sequence s_frame;
        (o_busy && !o_stack_we) ##1 (o_busy && o_stack_we) [*4]
            ##1 (!o_busy && o_stack_we) ##1 (!o_stack_we);
    endsequence
    a_sp_window: assert property (
        o_stack_pointer[15:7] == 9'h002) else $error("sp left its window");
    a_sp_reinit: assert property (
        i_stack_reinit_op && !o_busy |=> o_stack_pointer == 16'h017F)
        else $error("sp not back at top");
    a_push_dec: assert property (
        i_push && sp_free |=> o_stack_pointer[6:0] ==
        $past(o_stack_pointer[6:0]) - 7'h01) else $error("push step wrong");
    a_pop_inc: assert property (
        i_pop && !i_push && sp_free |=> o_stack_pointer[6:0] ==
        $past(o_stack_pointer[6:0]) + 7'h01) else $error("pop step wrong");
    a_zero_flag: assert property (
        i_alu_valid && !o_busy && !i_flags_write |=>
        o_condition_flags[1] == (o_alu_result == 8'h00))
        else $error("zero flag wrong");
    a_irq_disable: assert property (
        o_irq_disabled == (o_condition_flags[5] & o_condition_flags[3]))
        else $error("disable out of step with level");
    a_mask_level3: assert property (
        i_mask_interrupts_op && !o_busy && !i_flags_write && !seq_op |=>
        o_condition_flags[5] && o_condition_flags[3])
        else $error("mask did not reach level 3");
    a_irq_frame: assert property (s_irq_take |=> s_frame)
        else $error("entry frame not five writes");
    a_pcl_first: assert property (s_irq_take |=> ##1
        o_stack_we && o_stack_addr == $past(o_stack_pointer) &&
        o_stack_wdata == $past(o_program_counter[7:0], 2))
        else $error("first saved byte wrong");
    a_prio_load: assert property (s_irq_take |=>
        {o_condition_flags[5], o_condition_flags[3]} ==
        $past(i_vector_priority)) else $error("entry level not loaded");
endmodule
bind cfsp_regs cfsp_regs_properties #(.SP_BITS(SP_BITS)) u_props (.*);
`default_nettype wire

/* File: verif/cfsp_stack_ram.sv */
// Stack RAM model on the memory side of the one-byte stack port.
// Assumes read data is taken in the cycle of the read strobe itself.
`timescale 1ns/100ps
`default_nettype none
module cfsp_stack_ram (
    input wire logic i_sys_clk,
    input wire logic i_we,
    input wire logic i_re,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    output var logic [7:0] o_rdata
);
    logic [7:0] mem [0:127];
    always @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_addr[6:0]] <= i_wdata;
        end
    end
    // Inverted outside a read, so a mistimed sample never sees good data
    assign o_rdata = i_re ? mem[i_addr[6:0]] : ~mem[i_addr[6:0]];
endmodule
`default_nettype wire

/* File: verif/cpu_flags_and_stack_pointer_test.sv */
// Self-checking bench for the flag and stack pointer register file.
// Assumes cfsp_regs, its package, checker and stack RAM compiled first.
`timescale 1ns/100ps
`default_nettype none
module cpu_flags_and_stack_pointer_test;
    logic i_sys_clk, i_reset_n, i_alu_valid, i_shift_carry, i_test_bit;
    logic i_set_overflow_op, i_clear_overflow_op, i_mask_interrupts_op;
    logic i_unmask_interrupts_op, i_halt_op, i_wait_for_irq_op;
    logic i_flags_write, i_pc_load, i_pc_low_write, i_pc_high_write;
    logic i_stack_reinit_op, i_load_op, i_push, i_pop, i_call;
    logic i_irq_entry, i_interrupt_return_op, o_irq_disabled, o_stack_we;
    logic o_stack_re, o_busy, o_x_load, o_a_load;
    logic [1:0] i_vector_priority;
    logic [3:0] i_alu_op;
    logic [7:0] i_alu_a, i_alu_b, i_flags_wdata, i_pc_byte, i_sp_low_wdata;
    logic [7:0] i_index_x, i_accum, i_stack_rdata, o_condition_flags;
    logic [7:0] o_alu_result, o_stack_wdata, o_restore_data;
    logic [15:0] i_pc_wdata, o_stack_pointer, o_program_counter;
    logic [15:0] o_stack_addr;
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    cfsp_regs #(.SP_BITS(7)) dut (.*);
    cfsp_stack_ram ram (.i_sys_clk(i_sys_clk), .i_we(o_stack_we),
        .i_re(o_stack_re), .i_addr(o_stack_addr), .i_wdata(o_stack_wdata),
        .o_rdata(i_stack_rdata));

    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cycles++;
        // Whole run needs about fifty cycles
        if (cycles == 2000) begin
            errors++;
            summarize();
        end
    end

    task automatic idle();
        {i_alu_valid, i_set_overflow_op, i_clear_overflow_op,
            i_mask_interrupts_op, i_unmask_interrupts_op, i_halt_op,
            i_wait_for_irq_op, i_flags_write, i_pc_load, i_pc_low_write,
            i_pc_high_write, i_stack_reinit_op, i_load_op, i_push, i_pop,
            i_call, i_irq_entry, i_interrupt_return_op} = '0;
    endtask
    // Pulses last exactly one taken edge
    task automatic tick();
        @(posedge i_sys_clk);
        #1;
        idle();
    endtask
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        checked++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    function automatic logic [15:0] prio();
        return {13'h0, o_irq_disabled, o_condition_flags[5],
            o_condition_flags[3]};
    endfunction

    task automatic alu(logic [3:0] op, logic [7:0] a, b, r, m, f);
        i_alu_op = op;
        i_alu_a = a;
        i_alu_b = b;
        i_alu_valid = 1'b1;
        tick();
        if (op < 4'h6) chk("result", {8'h00, r}, {8'h00, o_alu_result});
        chk("flags", {8'h00, f & m}, {8'h00, o_condition_flags & m});
    endtask
    // Op codes follow cfsp_alu_op_t
    task automatic t_alu();
        alu(4'h1, 8'h08, 8'h08, 8'h10, 8'h17, 8'h10);
        alu(4'h1, 8'h80, 8'h80, 8'h00, 8'h17, 8'h03);
        alu(4'h2, 8'h0F, 8'h00, 8'h10, 8'h17, 8'h10);
        alu(4'h3, 8'h00, 8'h01, 8'hFF, 8'h07, 8'h05);
        alu(4'h4, 8'h05, 8'h02, 8'h02, 8'h07, 8'h00);
        alu(4'h5, 8'h00, 8'h80, 8'h80, 8'h06, 8'h04);
        alu(4'h0, 8'h00, 8'h00, 8'h00, 8'h06, 8'h02);
        alu(4'h6, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01);
        alu(4'h7, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00);
        i_set_overflow_op = 1'b1;
        i_clear_overflow_op = 1'b1;
        tick();
        chk("carry", 16'h0001, {15'h0, o_condition_flags[0]});
        i_clear_overflow_op = 1'b1;
        tick();
        chk("carry", 16'h0000, {15'h0, o_condition_flags[0]});
    endtask
    task automatic pri(logic [3:0] ops, logic [2:0] e);
        {i_mask_interrupts_op, i_unmask_interrupts_op, i_halt_op,
            i_wait_for_irq_op} = ops;
        tick();
        chk("priority", {13'h0, e}, prio());
    endtask
    task automatic t_prio();
        pri(4'h8, 3'h7);
        pri(4'h4, 3'h2);
        pri(4'h8, 3'h7);
        pri(4'h2, 3'h2);
        pri(4'h8, 3'h7);
        pri(4'h1, 3'h2);
        i_flags_write = 1'b1;
        i_flags_wdata = 8'h08;
        tick();
        chk("flags pop", 16'h0008, {8'h00, o_condition_flags});
    endtask
    task automatic sp_op(logic [3:0] ops, logic [7:0] d, logic [15:0] e);
        {i_stack_reinit_op, i_load_op, i_push, i_pop} = ops;
        i_sp_low_wdata = d;
        tick();
        chk("stack pointer", e, o_stack_pointer);
    endtask
    task automatic t_stack();
        sp_op(4'h4, 8'h80, 16'h0100);
        sp_op(4'h2, 8'h00, 16'h017F);
        sp_op(4'h1, 8'h00, 16'h0100);
        sp_op(4'h4, 8'h85, 16'h0105);
        sp_op(4'h2, 8'h00, 16'h0104);
        sp_op(4'h1, 8'h00, 16'h0105);
        sp_op(4'h8, 8'h00, 16'h017F);
    endtask
    task automatic frame(int n, logic [39:0] d, logic [15:0] top);
        // First write strobe comes one cycle after the sequence is taken
        tick();
        for (int k = 0; k < n; k++) begin
            chk("write addr", top - 16'(k), o_stack_addr);
            chk("write data", {8'h01, d[8*k+:8]},
                {7'h00, o_stack_we, o_stack_wdata});
            tick();
        end
        chk("busy", 16'h0000, {15'h0, o_busy});
    endtask
    task automatic t_frames();
        logic [7:0] f;
        int n;
        int loads = 0;
        i_pc_low_write = 1'b1;
        i_pc_byte = 8'h34;
        tick();
        i_pc_high_write = 1'b1;
        i_pc_byte = 8'h12;
        tick();
        chk("pc", 16'h1234, o_program_counter);
        i_call = 1'b1;
        tick();
        frame(2, 40'h1234, 16'h017F);
        f = o_condition_flags;
        i_index_x = 8'hA5;
        i_accum = 8'h5A;
        i_vector_priority = 2'h1;
        i_irq_entry = 1'b1;
        tick();
        chk("entry level", 16'h0001, prio());
        frame(5, {f, 32'h5AA51234}, 16'h017D);
        chk("sp after entry", 16'h0178, o_stack_pointer);
        i_pc_load = 1'b1;
        i_pc_wdata = 16'hBEEF;
        i_mask_interrupts_op = 1'b1;
        tick();
        i_interrupt_return_op = 1'b1;
        tick();
        for (n = 0; n < 30 && o_busy === 1'b1; n++) begin
            if (o_x_load) chk("x", 16'h00A5, {8'h00, o_restore_data});
            if (o_a_load) chk("a", 16'h005A, {8'h00, o_restore_data});
            loads += int'(o_x_load) + int'(o_a_load);
            tick();
        end
        chk("restore loads", 16'h0002, 16'(loads));
        chk("pc back", 16'h1234, o_program_counter);
        chk("flags back", {8'h00, f}, {8'h00, o_condition_flags});
        chk("sp back", 16'h017D, o_stack_pointer);
    endtask

    initial begin
        idle();
        {i_alu_op, i_alu_a, i_alu_b, i_flags_wdata, i_pc_byte} = '0;
        {i_sp_low_wdata, i_index_x, i_accum, i_pc_wdata} = '0;
        i_vector_priority = 2'h0;
        i_shift_carry = 1'b1;
        i_test_bit = 1'b0;
        i_reset_n = 1'b0;
        repeat (6) tick();
        i_reset_n = 1'b1;
        chk("reset sp", 16'h017F, o_stack_pointer);
        chk("reset level", 16'h0007, prio());
        t_alu();
        t_prio();
        t_stack();
        t_frames();
        summarize();
    end
endmodule
`default_nettype wire
